/* File: core/rstseq_irq_arbiter.sv */
`timescale 1ns/100ps
module rstseq_irq_arbiter (
	input  wire logic                                 pclk,
	input  wire logic                                 presetn,
	input  wire logic                                 hold_reset,
	input  wire logic [rstseq_pkg::IRQ_COUNT-1:0]      irq_req,
	input  wire logic [rstseq_pkg::IRQ_COUNT-1:0]      irq_enable,
	input  wire logic                                 cpu_mask,
	input  wire logic                                 instr_done,
	input  wire logic                                 irq_serviced,
	output logic                                      irq_latched,
	output logic [rstseq_pkg::IRQ_CODE_WIDTH-1:0]      irq_code,
	output logic                                      irq_entry
);

	// ****************************************************
	// Priority decode, lowest index wins
	// ****************************************************
	function automatic logic [rstseq_pkg::IRQ_CODE_WIDTH-1:0] prio_code(
		input logic [rstseq_pkg::IRQ_COUNT-1:0] req
	);
		logic [rstseq_pkg::IRQ_CODE_WIDTH-1:0] code;
		code = '0;
		for (int i = rstseq_pkg::IRQ_COUNT - 1; i >= 0; i--) begin
			if (req[i]) begin
				code = rstseq_pkg::IRQ_CODE_WIDTH'(i);
			end
		end
		return code;
	endfunction

	logic [rstseq_pkg::IRQ_COUNT-1:0] active;
	logic                             mask_prev;
	logic                             mask_fell;
	logic                             take;
	logic                             release_now;

	assign active      = irq_req & irq_enable;
	assign mask_fell   = mask_prev & ~cpu_mask;
	assign take        = instr_done & ~cpu_mask & (|active) & ~irq_latched;
	assign release_now = irq_serviced | mask_fell;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_latched <= 1'b0;
			irq_code    <= '0;
			irq_entry   <= 1'b0;
			mask_prev   <= 1'b0;
		end else begin
			mask_prev <= cpu_mask;
			irq_entry <= take & ~hold_reset;
			if (hold_reset) begin
				irq_latched <= 1'b0;
			end else if (take) begin
				irq_latched <= 1'b1;
				irq_code    <= prio_code(active);
			end else if (release_now) begin
				irq_latched <= 1'b0;
			end
		end
	end

endmodule

/* File: core/rstseq_pkg.sv */
package rstseq_pkg;

	// ****************************************************
	// Register map
	// ****************************************************
	localparam logic [11:0] CAUSE_OFFSET   = 12'h000;
	localparam logic [11:0] CONFIG_OFFSET  = 12'h004;
	localparam logic [11:0] COUNTER_OFFSET = 12'h008;

	// Reset cause register fields
	localparam int CAUSE_POR_BIT  = 7;
	localparam int CAUSE_PIN_BIT  = 6;
	localparam int CAUSE_WDOG_BIT = 5;
	localparam int CAUSE_ILLEGAL_OPCODE_FLAG_BIT = 4;
	localparam int CAUSE_ILLEGAL_ADDRESS_FLAG_BIT = 3;
	localparam int CAUSE_LOWV_BIT = 1;
	localparam logic [7:0] CAUSE_POR_VALUE = 8'h80;

	// Configuration register fields
	localparam int CFG_WDOG_DISABLE_BIT = 0;
	localparam int CFG_STOP_ENABLE_BIT  = 1;
	localparam int CFG_SHORT_REC_BIT    = 2;
	localparam int CFG_LOWV_PWRD_BIT    = 3;
	localparam int CFG_LOWV_RSTD_BIT    = 4;
	localparam int CFG_WIDTH            = 5;
	localparam logic [4:0] CFG_RESET_VALUE = 5'h00;

	// ****************************************************
	// Timing, in oscillator cycles
	// ****************************************************
	localparam int CTR_WIDTH       = 12;
	localparam int LONG_CYCLES     = 4096;
	localparam int SHORT_CYCLES    = 32;
	localparam int PIN_MIN_CYCLES  = 67;
	localparam logic [11:0] LONG_LAST  = 12'(LONG_CYCLES - 1);
	localparam logic [11:0] SHORT_LAST = 12'(SHORT_CYCLES - 1);
	localparam logic [11:0] HOLD_LAST  = 12'(2 * SHORT_CYCLES - 1);
	localparam int PIN_CNT_WIDTH   = 7;
	localparam logic [6:0] PIN_MIN = 7'(PIN_MIN_CYCLES);

	// ****************************************************
	// Vectors and interrupts
	// ****************************************************
	localparam logic [15:0] RESET_VECTOR   = 16'hfffe;
	localparam logic [15:0] MONITOR_VECTOR = 16'hfefe;
	localparam int IRQ_COUNT      = 8;
	localparam int IRQ_CODE_WIDTH = 3;

	// Number of asynchronous inputs brought into the clock domain
	localparam int SYNC_COUNT = 4;
	localparam int SYNC_POR   = 0;
	localparam int SYNC_LOWV  = 1;
	localparam int SYNC_WDOG  = 2;
	localparam int SYNC_PIN   = 3;

	typedef enum logic [2:0] {
		RSTSEQ_RUN,
		RSTSEQ_LONG,
		RSTSEQ_PIN,
		RSTSEQ_HOLD,
		RSTSEQ_EXT,
		RSTSEQ_STOP,
		RSTSEQ_RECOVER
	} rstseq_state_t;

endpackage

/* File: core/rstseq_sync.sv */
`timescale 1ns/100ps
module rstseq_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic async_in,
	input  wire logic reset_level,
	output logic      sync_out
);

	// ****************************************************
	// Two-stage synchroniser
	// ****************************************************
	logic stage1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1   <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			stage1   <= async_in ^ reset_level;
			sync_out <= stage1;
		end
	end

endmodule

/* File: core/rstseq_top.sv */
// Summary of operation
// - Any reset asserts internal reset, defaults registers, picks normal or monitor vector
// - Internal resets clear the system counter; external pin reset leaves it alone
// - Each reset sets the cause bit of its own source
// - Pin low halts; pin flag set after 67 low cycles unless power/low-voltage
// - Internal resets drive the pin low 32 cycles, then hold reset 32 more
// - Power-on and low-voltage first count 4096 cycles with the pin low
// - Power-on enables bus clock, gates core clocks 4096 cycles, releases 64 later
// - Power-on sets its cause bit and clears all others
// - Watchdog overflow resets and flags when watchdog not disabled
// - Watchdog request is treated as asynchronous
// - Illegal instruction sets its flag and resets the chip
// - Stop with stop disabled acts as an illegal opcode reset
// - Unmapped address resets only on opcode fetch, never on data fetch
// - Low voltage resets when both disables clear; long count after recovery
// - System counter is 12 bits and advances on the falling clock edge
// - Counter overflow clocks the watchdog as its prescaler
// - Stop instruction clears the counter to time the recovery
// - Wake samples short-recovery bit: 31 cycles when set, else 4095
// - Counter runs freely after every reset state
// - Pending interrupts are latched and arbitrated into a vector code
// - A latched interrupt is held until serviced or mask cleared
// - Interrupts are taken after instruction end, unmasked, enabled, lowest index first
// - Resets override interrupts and bypass arbitration
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
module rstseq_top (
	input  wire logic                                pclk,
	input  wire logic                                presetn,
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [11:0]                         paddr,
	input  wire logic [31:0]                         pwdata,
	output logic      [31:0]                         prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	input  wire logic                                power_up_pulse,
	input  wire logic                                low_voltage_detector,
	input  wire logic                                watchdog_overflow,
	input  wire logic                                reset_pin_in,
	output logic                                     reset_pin_out,
	output logic                                     reset_pin_oe_n,
	input  wire logic                                illegal_opcode,
	input  wire logic                                unmapped_access,
	input  wire logic                                opcode_fetch,
	input  wire logic                                stop_instr,
	input  wire logic                                wake_event,
	input  wire logic                                monitor_mode,
	input  wire logic [rstseq_pkg::IRQ_COUNT-1:0]     irq_req,
	input  wire logic [rstseq_pkg::IRQ_COUNT-1:0]     irq_enable,
	input  wire logic                                cpu_mask,
	input  wire logic                                instr_done,
	input  wire logic                                irq_serviced,
	output logic                                     internal_reset_signal,
	output logic                                     bus_clock_source,
	output logic                                     internal_bus_clocks,
	output logic      [15:0]                         reset_vector,
	output logic                                     watchdog_clock,
	output logic                                     irq_latched,
	output logic      [rstseq_pkg::IRQ_CODE_WIDTH-1:0] irq_code,
	output logic                                     irq_entry
);

	// ****************************************************
	// Synchronisers
	// ****************************************************
	logic [rstseq_pkg::SYNC_COUNT-1:0] async_bus;
	logic [rstseq_pkg::SYNC_COUNT-1:0] sync_bus;
	logic [rstseq_pkg::SYNC_COUNT-1:0] sync_invert;

	assign async_bus[rstseq_pkg::SYNC_POR]  = power_up_pulse;
	assign async_bus[rstseq_pkg::SYNC_LOWV] = low_voltage_detector;
	assign async_bus[rstseq_pkg::SYNC_WDOG] = watchdog_overflow;
	assign async_bus[rstseq_pkg::SYNC_PIN]  = reset_pin_in;
	// Pin is active low: inverted so the synchroniser yields "pin low"
	assign sync_invert = 4'h8;

	genvar gi;
	generate
		for (gi = 0; gi < rstseq_pkg::SYNC_COUNT; gi++) begin : g_sync
			rstseq_sync u_sync (
				.pclk        (pclk),
				.presetn     (presetn),
				.async_in    (async_bus[gi]),
				.reset_level (sync_invert[gi]),
				.sync_out    (sync_bus[gi])
			);
		end
	endgenerate

	logic por_s;
	logic lowv_s;
	logic wdog_s;
	logic pin_low_s;

	assign por_s     = sync_bus[rstseq_pkg::SYNC_POR];
	assign lowv_s    = sync_bus[rstseq_pkg::SYNC_LOWV];
	assign wdog_s    = sync_bus[rstseq_pkg::SYNC_WDOG];
	assign pin_low_s = sync_bus[rstseq_pkg::SYNC_PIN];

	// ****************************************************
	// Registers and their decode
	// ****************************************************
	logic [7:0]                     cause;
	logic [rstseq_pkg::CFG_WIDTH-1:0] config_reg;
	logic [rstseq_pkg::CTR_WIDTH-1:0] sys_count;

	logic sel_cause;
	logic sel_config;
	logic sel_counter;
	logic mapped;
	logic wr_fire;
	logic rd_fire;
	logic setup;
	logic [31:0] rd_mux;

	assign sel_cause   = (paddr == rstseq_pkg::CAUSE_OFFSET);
	assign sel_config  = (paddr == rstseq_pkg::CONFIG_OFFSET);
	assign sel_counter = (paddr == rstseq_pkg::COUNTER_OFFSET);
	assign mapped      = sel_cause | sel_config | sel_counter;
	assign setup       = psel & ~penable;
	assign wr_fire     = psel & penable & pready & pwrite;
	assign rd_fire     = psel & penable & pready & ~pwrite;
	assign rd_mux      = sel_cause   ? {24'h000000, cause} :
	                     sel_config  ? {27'h0000000, config_reg} :
	                     sel_counter ? {20'h00000, sys_count} :
	                     32'h00000000;

	logic cfg_wdog_dis;
	logic cfg_stop_en;
	logic cfg_short_rec;
	logic cfg_lowv_pwrd;
	logic cfg_lowv_rstd;

	assign cfg_wdog_dis  = config_reg[rstseq_pkg::CFG_WDOG_DISABLE_BIT];
	assign cfg_stop_en   = config_reg[rstseq_pkg::CFG_STOP_ENABLE_BIT];
	assign cfg_short_rec = config_reg[rstseq_pkg::CFG_SHORT_REC_BIT];
	assign cfg_lowv_pwrd = config_reg[rstseq_pkg::CFG_LOWV_PWRD_BIT];
	assign cfg_lowv_rstd = config_reg[rstseq_pkg::CFG_LOWV_RSTD_BIT];

	// ****************************************************
	// Reset source qualification
	// ****************************************************
	rstseq_pkg::rstseq_state_t state;
	rstseq_pkg::rstseq_state_t next_state;
	logic                     clear_ctr;
	logic                     next_clear_ctr;
	logic                     short_sel;
	logic [rstseq_pkg::PIN_CNT_WIDTH-1:0] pin_count;

	logic in_run;
	logic can_take;
	logic lowv_req;
	logic wdog_req;
	logic illegal_opcode_flag_req;
	logic illegal_address_flag_req;
	logic stop_ok;
	logic ext_req;
	logic long_req;
	logic short_req;
	logic ctr_at_short;
	logic ctr_at_hold;
	logic ctr_at_long;
	logic pin_flag_set;

	assign in_run   = (state == rstseq_pkg::RSTSEQ_RUN);
	assign can_take = in_run | (state == rstseq_pkg::RSTSEQ_STOP)
	                | (state == rstseq_pkg::RSTSEQ_RECOVER);
	assign lowv_req = lowv_s & ~cfg_lowv_pwrd & ~cfg_lowv_rstd;
	assign wdog_req = can_take & wdog_s & ~cfg_wdog_dis;
	assign illegal_opcode_flag_req = in_run & (illegal_opcode
	                | (stop_instr & ~cfg_stop_en));
	assign illegal_address_flag_req = in_run & unmapped_access & opcode_fetch;
	assign stop_ok  = in_run & stop_instr & cfg_stop_en;
	assign ext_req  = can_take & pin_low_s;
	assign long_req = por_s | lowv_req;
	assign short_req = wdog_req | illegal_opcode_flag_req | illegal_address_flag_req;

	assign ctr_at_short = ~clear_ctr & (sys_count == rstseq_pkg::SHORT_LAST);
	assign ctr_at_hold  = ~clear_ctr & (sys_count == rstseq_pkg::HOLD_LAST);
	assign ctr_at_long  = ~clear_ctr & (sys_count == rstseq_pkg::LONG_LAST);
	assign pin_flag_set = (state == rstseq_pkg::RSTSEQ_EXT)
	                    & (pin_count == rstseq_pkg::PIN_MIN - 7'h01)
	                    & ~cause[rstseq_pkg::CAUSE_POR_BIT]
	                    & ~cause[rstseq_pkg::CAUSE_LOWV_BIT];

	// ****************************************************
	// Sequencer next state
	// ****************************************************
	always_comb begin
		next_state     = state;
		next_clear_ctr = 1'b0;
		if (long_req) begin
			next_state     = rstseq_pkg::RSTSEQ_LONG;
			next_clear_ctr = 1'b1;
		end else if (short_req) begin
			next_state     = rstseq_pkg::RSTSEQ_PIN;
			next_clear_ctr = 1'b1;
		end else begin
			case (state)
				rstseq_pkg::RSTSEQ_RUN: begin
					if (ext_req) begin
						next_state = rstseq_pkg::RSTSEQ_EXT;
					end else if (stop_ok) begin
						next_state     = rstseq_pkg::RSTSEQ_STOP;
						next_clear_ctr = 1'b1;
					end
				end
				rstseq_pkg::RSTSEQ_LONG: begin
					if (ctr_at_long) begin
						next_state = rstseq_pkg::RSTSEQ_PIN;
					end
				end
				rstseq_pkg::RSTSEQ_PIN: begin
					if (ctr_at_short) begin
						next_state = rstseq_pkg::RSTSEQ_HOLD;
					end
				end
				rstseq_pkg::RSTSEQ_HOLD: begin
					if (ctr_at_hold) begin
						next_state = rstseq_pkg::RSTSEQ_RUN;
					end
				end
				rstseq_pkg::RSTSEQ_EXT: begin
					if (!pin_low_s) begin
						next_state = rstseq_pkg::RSTSEQ_RUN;
					end
				end
				rstseq_pkg::RSTSEQ_STOP: begin
					if (ext_req) begin
						next_state = rstseq_pkg::RSTSEQ_EXT;
					end else if (wake_event) begin
						next_state = rstseq_pkg::RSTSEQ_RECOVER;
					end else begin
						next_clear_ctr = 1'b1;
					end
				end
				rstseq_pkg::RSTSEQ_RECOVER: begin
					if (ext_req) begin
						next_state = rstseq_pkg::RSTSEQ_EXT;
					end else if (short_sel ? ctr_at_short : ctr_at_long) begin
						next_state = rstseq_pkg::RSTSEQ_RUN;
					end
				end
				default: begin
					next_state = rstseq_pkg::RSTSEQ_RUN;
				end
			endcase
		end
	end

	logic next_internal_reset_signal;
	logic next_pin_drive;
	logic next_core_clk;

	assign next_internal_reset_signal = (next_state == rstseq_pkg::RSTSEQ_LONG)
	                 | (next_state == rstseq_pkg::RSTSEQ_PIN)
	                 | (next_state == rstseq_pkg::RSTSEQ_HOLD)
	                 | (next_state == rstseq_pkg::RSTSEQ_EXT);
	assign next_pin_drive = (next_state == rstseq_pkg::RSTSEQ_LONG)
	                      | (next_state == rstseq_pkg::RSTSEQ_PIN);
	assign next_core_clk = (next_state != rstseq_pkg::RSTSEQ_LONG)
	                     & (next_state != rstseq_pkg::RSTSEQ_STOP)
	                     & (next_state != rstseq_pkg::RSTSEQ_RECOVER);

	// ****************************************************
	// Sequencer state and outputs
	// ****************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state                 <= rstseq_pkg::RSTSEQ_LONG;
			clear_ctr             <= 1'b1;
			internal_reset_signal <= 1'b1;
			reset_pin_oe_n        <= 1'b0;
			reset_pin_out         <= 1'b0;
			internal_bus_clocks   <= 1'b0;
			bus_clock_source      <= 1'b0;
			short_sel             <= 1'b0;
		end else begin
			state                 <= next_state;
			clear_ctr             <= next_clear_ctr
			                       | (next_state == rstseq_pkg::RSTSEQ_LONG
			                          & lowv_req);
			internal_reset_signal <= next_internal_reset_signal;
			reset_pin_oe_n        <= ~next_pin_drive;
			reset_pin_out         <= 1'b0;
			internal_bus_clocks   <= next_core_clk;
			bus_clock_source      <= 1'b1;
			if (state == rstseq_pkg::RSTSEQ_STOP && wake_event) begin
				short_sel <= cfg_short_rec;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_count <= '0;
		end else if (state != rstseq_pkg::RSTSEQ_EXT) begin
			pin_count <= '0;
		end else if (pin_count != rstseq_pkg::PIN_MIN) begin
			pin_count <= pin_count + 7'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_vector <= rstseq_pkg::RESET_VECTOR;
		end else if (next_internal_reset_signal) begin
			reset_vector <= monitor_mode ? rstseq_pkg::MONITOR_VECTOR
			                             : rstseq_pkg::RESET_VECTOR;
		end
	end

	// ****************************************************
	// System counter, falling edge
	// ****************************************************
	always_ff @(negedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_count      <= '0;
			watchdog_clock <= 1'b0;
		end else begin
			if (clear_ctr) begin
				sys_count <= '0;
			end else begin
				sys_count <= sys_count + 12'h001;
			end
			watchdog_clock <= sys_count[rstseq_pkg::CTR_WIDTH-1];
		end
	end

	// ****************************************************
	// Cause and configuration registers
	// ****************************************************
	logic [7:0] cause_set;

	assign cause_set[rstseq_pkg::CAUSE_POR_BIT]  = 1'b0;
	assign cause_set[rstseq_pkg::CAUSE_PIN_BIT]  = pin_flag_set;
	assign cause_set[rstseq_pkg::CAUSE_WDOG_BIT] = wdog_req & ~long_req;
	assign cause_set[rstseq_pkg::CAUSE_ILLEGAL_OPCODE_FLAG_BIT] = illegal_opcode_flag_req & ~long_req;
	assign cause_set[rstseq_pkg::CAUSE_ILLEGAL_ADDRESS_FLAG_BIT] = illegal_address_flag_req & ~long_req
	                                             & ~illegal_opcode_flag_req;
	assign cause_set[2]                          = 1'b0;
	assign cause_set[rstseq_pkg::CAUSE_LOWV_BIT] = lowv_req & ~por_s;
	assign cause_set[0]                          = 1'b0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cause <= rstseq_pkg::CAUSE_POR_VALUE;
		end else if (por_s) begin
			cause <= rstseq_pkg::CAUSE_POR_VALUE;
		end else if (rd_fire && sel_cause) begin
			cause <= cause_set;
		end else begin
			cause <= cause | cause_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_reg <= rstseq_pkg::CFG_RESET_VALUE;
		end else if (internal_reset_signal) begin
			config_reg <= rstseq_pkg::CFG_RESET_VALUE;
		end else if (wr_fire && sel_config) begin
			config_reg <= pwdata[rstseq_pkg::CFG_WIDTH-1:0];
		end
	end

	// ****************************************************
	// APB slave, one wait state
	// ****************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			if (setup) begin
				prdata <= pwrite ? 32'h00000000 : rd_mux;
			end
		end
	end

	// ****************************************************
	// Interrupt latch and arbitration
	// ****************************************************
	rstseq_irq_arbiter u_arb (
		.pclk         (pclk),
		.presetn      (presetn),
		.hold_reset   (internal_reset_signal),
		.irq_req      (irq_req),
		.irq_enable   (irq_enable),
		.cpu_mask     (cpu_mask),
		.instr_done   (instr_done),
		.irq_serviced (irq_serviced),
		.irq_latched  (irq_latched),
		.irq_code     (irq_code),
		.irq_entry    (irq_entry)
	);

endmodule

/* File: verification/rstseq_reset_line.sv */
`timescale 1ns/100ps
module rstseq_reset_line (
	input wire logic pull_low,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe_n,
	output logic     reset_pin_in
);
	// ****************************************************
	// Open-drain reset line with pull-up
	// ****************************************************
	assign reset_pin_in = (reset_pin_oe_n | reset_pin_out) & !pull_low;
endmodule

/* File: verification/rstseq_top_properties.sv */
`timescale 1ns/100ps
module rstseq_top_checker (
	input wire logic                                 pclk,
	input wire logic                                 presetn,
	input wire logic                                 reset_pin_oe_n,
	input wire logic                                 reset_pin_in,
	input wire logic                                 internal_reset_signal,
	input wire logic                                 internal_bus_clocks,
	input wire logic                                 illegal_opcode,
	input wire logic                                 unmapped_access,
	input wire logic                                 opcode_fetch,
	input wire logic                                 monitor_mode,
	input wire logic [15:0]                          reset_vector,
	input wire logic [rstseq_pkg::IRQ_COUNT-1:0]      irq_req,
	input wire logic [rstseq_pkg::IRQ_COUNT-1:0]      irq_enable,
	input wire logic                                 cpu_mask,
	input wire logic                                 instr_done,
	input wire logic                                 irq_serviced,
	input wire logic                                 irq_latched,
	input wire logic [rstseq_pkg::IRQ_CODE_WIDTH-1:0] irq_code,
	input wire logic                                 irq_entry
);
	// ****************************************************
	// Reset and interrupt properties
	// ****************************************************
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	pin_in_reset_a: assert property (
		!reset_pin_oe_n |-> internal_reset_signal)
		else $error("Pin driven outside internal reset");
	reset_tail_a: assert property (
		$rose(reset_pin_oe_n) |-> internal_reset_signal[*8]
		##[20:28] !internal_reset_signal)
		else $error("Reset tail after pin release has wrong length");
	illegal_opcode_flag_reset_a: assert property (
		illegal_opcode && internal_bus_clocks && !internal_reset_signal
		|-> ##[1:3] !reset_pin_oe_n)
		else $error("Illegal opcode did not drive the pin");
	illegal_address_flag_fetch_a: assert property (
		unmapped_access && opcode_fetch && internal_bus_clocks
		&& !internal_reset_signal |-> ##[1:3] internal_reset_signal)
		else $error("Unmapped opcode fetch did not reset");
	data_fetch_a: assert property (
		unmapped_access && !opcode_fetch && !illegal_opcode && reset_pin_in
		&& !internal_reset_signal |=> !internal_reset_signal)
		else $error("Unmapped data fetch caused a reset");
	irq_take_a: assert property (
		instr_done && !cpu_mask && (|(irq_req & irq_enable)) && !irq_latched
		&& !internal_reset_signal |=> irq_entry && irq_latched)
		else $error("Pending interrupt not latched");
	irq_hold_a: assert property (
		irq_latched && !irq_serviced && !$fell(cpu_mask)
		&& !internal_reset_signal |=> irq_latched && $stable(irq_code))
		else $error("Latched interrupt displaced");
	entry_pulse_a: assert property (
		irq_entry |=> !irq_entry)
		else $error("Entry pulse longer than one cycle");
	vector_pick_a: assert property (
		(internal_reset_signal && $stable(monitor_mode))[*3] |=>
		reset_vector == ($past(monitor_mode) ? rstseq_pkg::MONITOR_VECTOR
		: rstseq_pkg::RESET_VECTOR))
		else $error("Wrong reset vector");
	cover property ($rose(reset_pin_oe_n));
	cover property (irq_entry);
	cover property (unmapped_access && opcode_fetch);
endmodule

bind rstseq_top rstseq_top_checker u_rstseq_top_checker (.pclk, .presetn,
	.reset_pin_oe_n, .reset_pin_in, .internal_reset_signal,
	.internal_bus_clocks, .illegal_opcode, .unmapped_access, .opcode_fetch,
	.monitor_mode, .reset_vector, .irq_req, .irq_enable, .cpu_mask,
	.instr_done, .irq_serviced, .irq_latched, .irq_code, .irq_entry);

/* File: verification/tb_rstseq_top.sv */
`timescale 1ns/100ps
module tb_rstseq_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        power_up_pulse, low_voltage_detector, watchdog_overflow;
	logic        reset_pin_in, reset_pin_out, reset_pin_oe_n, pull_low;
	logic        illegal_opcode, unmapped_access, opcode_fetch, stop_instr;
	logic        wake_event, monitor_mode, cpu_mask, instr_done, irq_serviced;
	logic        internal_reset_signal, bus_clock_source, internal_bus_clocks;
	logic        watchdog_clock, irq_latched, irq_entry;
	logic [7:0]  irq_req, irq_enable;
	logic [15:0] reset_vector;
	logic [2:0]  irq_code;
	logic [4:0]  src;
	logic [4:0]  srcs [4] = '{5'h10, 5'h08, 5'h04, 5'h03};
	logic [7:0]  causes [4] = '{8'h10, 8'h10, 8'h20, 8'h08};
	int          fails, total_checks, cyc, n, exp;
	assign {illegal_opcode, stop_instr, watchdog_overflow, unmapped_access,
		opcode_fetch} = src;
	rstseq_top u_rstseq_top (.*);
	rstseq_reset_line u_rstseq_reset_line (.*);
	// ****************************************************
	// Shared tasks
	// ****************************************************
	task check(input logic [31:0] got, input logic [31:0] want);
		total_checks++;
		if (got !== want) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task reset_run(input int p, input logic [7:0] cause);
		n = 0;
		for (int i = 0; i < 10 && internal_reset_signal !== 1'b1; i++)
			@(posedge pclk);
		while (reset_pin_oe_n === 1'b0) begin
			n++;
			@(posedge pclk);
		end
		check((n >= p && n <= p + 4) ? p : n, p);
		while (internal_reset_signal === 1'b1) @(posedge pclk);
		check({internal_bus_clocks, bus_clock_source}, 2'b11);
		apb(1'b0, 12'h000, 32'h0);
		check(rd, {24'h0, cause});
		$display("Reset test done, cause %h", cause);
	endtask
	task tally_and_finish();
		$display("Checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ****************************************************
	// Clock, timeout and tests
	// ****************************************************
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			tally_and_finish();
		end
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, src, power_up_pulse, presetn,
			low_voltage_detector, wake_event, monitor_mode, cpu_mask,
			instr_done, irq_serviced, irq_req, irq_enable, pull_low} = '0;
		void'($urandom(32'h07673ec7));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		reset_run(4128, 8'h80);
		for (int k = 0; k < 4; k++) begin
			monitor_mode <= k[0];
			src <= srcs[k];
			@(posedge pclk);
			src <= '0;
			reset_run(32, causes[k]);
		end
		src <= 5'h02;
		@(posedge pclk);
		src <= '0;
		apb(1'b1, 12'h004, 32'h1);
		src <= 5'h04;
		@(posedge pclk);
		src <= '0;
		repeat (20) @(posedge pclk);
		check(32'(internal_reset_signal), 32'h0);
		apb(1'b0, 12'h0ff, 32'h0);
		check(32'(err), 32'h1);
		pull_low <= 1'b1;
		repeat (80) @(posedge pclk);
		pull_low <= 1'b0;
		reset_run(0, 8'h40);
		apb(1'b1, 12'h004, 32'h6);
		src <= 5'h08;
		@(posedge pclk);
		src <= '0;
		wake_event <= 1'b1;
		repeat (20) @(posedge pclk);
		check(32'(internal_bus_clocks), 32'h0);
		repeat (16) @(posedge pclk);
		check(32'(internal_bus_clocks), 32'h1);
		for (int r = 0; r < 8; r++) begin
			irq_req <= 8'($urandom);
			irq_enable <= 8'($urandom);
			instr_done <= 1'b1;
			@(posedge pclk);
			instr_done <= 1'b0;
			@(posedge pclk);
			exp = 8;
			for (int b = 7; b >= 0; b--) if (irq_req[b] & irq_enable[b]) exp = b;
			check(32'(irq_latched), 32'(exp < 8));
			if (exp < 8) check(32'(irq_code), exp);
			irq_serviced <= 1'b1;
			@(posedge pclk);
			irq_serviced <= 1'b0;
			@(posedge pclk);
		end
		$display("Stop and interrupt tests done");
		tally_and_finish();
	end
endmodule
